// ==== logic/lpc_ctrl.sv ====
// Low-power clock state and management interrupt entry controller
`timescale 1ns/1ps
`default_nettype none
module lpc_ctrl
    import lpc_pkg::*;
(
    input  wire logic              core_clk_in,
    input  wire logic              arst_n_in,
    input  wire logic              sleep_request_n_in,
    input  wire logic              clock_halt_request_n_in,
    input  wire logic              mgmt_interrupt_n_in,
    input  wire logic              intr_in,
    input  wire logic              snoop_in,
    input  wire logic              ack_done_in,
    input  wire logic              state_saved_in,
    input  wire logic              mgmt_exit_in,
    input  wire logic              intr_taken_in,
    output logic [GATE_W-1:0]      clk_gate_en_out,
    output lpc_ack_s               bus_ack_out,
    output logic                   snoop_accept_out,
    output logic                   intr_service_out,
    output logic                   save_state_out,
    output logic                   mgmt_handler_start_out,
    output logic                   privileged_mgmt_mode_out,
    output logic                   executing_out,
    output lpc_state_e             state_out
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [$bits(lpc_req_s)-1:0] raw_req;
    logic [$bits(lpc_req_s)-1:0] sync_req;
    lpc_req_s                    req;

    // Sleep, halt and management pins are active low; invert before sampling so reset reads idle
    assign raw_req = {~sleep_request_n_in, ~clock_halt_request_n_in,
                      ~mgmt_interrupt_n_in, intr_in, snoop_in};

    lpc_sync #(
        .WIDTH   ($bits(lpc_req_s)),
        .RST_VAL (1'b0)
    ) u_sync (
        .core_clk_in (core_clk_in),
        .arst_n_in   (arst_n_in),
        .async_in    (raw_req),
        .sync_out    (sync_req)
    );

    assign req = lpc_req_s'(sync_req);

    // ------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------
    lpc_state_e        state_ff;
    lpc_state_e        nxt_state;
    logic              mgmt_pend_ff;
    logic              nxt_mgmt_pend;
    logic [GATE_W-1:0] gate_ff;
    logic [GATE_W-1:0] nxt_gate;
    lpc_ack_s          ack_ff;
    lpc_ack_s          nxt_ack;
    logic              snoop_ff;
    logic              nxt_snoop;
    logic              svc_ff;
    logic              nxt_svc;
    logic              save_ff;
    logic              nxt_save;
    logic              start_ff;
    logic              nxt_start;
    logic              mode_ff;
    logic              nxt_mode;
    logic              exec_ff;
    logic              nxt_exec;
    logic              intr_pending;
    logic              intr_capture;
    logic              mgmt_edge;
    logic              mgmt_prev_ff;
    logic              nxt_mgmt_prev;

    function automatic logic [GATE_W-1:0] gates_for(input lpc_state_e s);
        case (s)
            LPC_HALT, LPC_HALT_ACK: gates_for = GATES_HALT;
            LPC_SLEEP:              gates_for = GATES_SLEEP;
            default:                gates_for = GATES_ALL_ON;
        endcase
    endfunction

    // Interrupts are captured while not sleeping only
    assign intr_capture = req.intr_req && (state_ff != LPC_SLEEP);
    assign mgmt_edge    = req.mgmt_req && !mgmt_prev_ff;

    lpc_pend u_pend (
        .core_clk_in (core_clk_in),
        .arst_n_in   (arst_n_in),
        .capture_in  (intr_capture),
        .service_in  (intr_taken_in),
        .pending_out (intr_pending)
    );

    always_comb begin
        nxt_state     = state_ff;
        nxt_mgmt_pend = mgmt_pend_ff;
        nxt_ack       = '{valid: 1'b0, kind: LPC_ACK_NONE};
        nxt_save      = 1'b0;
        nxt_start     = 1'b0;
        nxt_mode      = mode_ff;
        nxt_mgmt_prev = req.mgmt_req;
        case (state_ff)
            LPC_RUN: begin
                if (req.halt_req) begin
                    nxt_state = LPC_HALT_ACK;
                    nxt_ack   = '{valid: 1'b1, kind: LPC_ACK_HALT};
                end else if (mgmt_pend_ff) begin
                    nxt_state     = LPC_MGMT_SAVE;
                    nxt_mgmt_pend = 1'b0;
                    nxt_save      = 1'b1;
                end
            end
            LPC_HALT_ACK: begin
                nxt_ack = ack_ff;
                if (ack_done_in) begin
                    nxt_ack   = '{valid: 1'b0, kind: LPC_ACK_NONE};
                    nxt_state = LPC_HALT;
                end
            end
            LPC_HALT: begin
                if (!req.halt_req) begin
                    nxt_state = mode_ff ? LPC_MGMT_RUN : LPC_RUN;
                end else if (req.sleep_req) begin
                    nxt_state = LPC_SLEEP;
                end
            end
            LPC_SLEEP: begin
                if (!req.sleep_req) begin
                    nxt_state = LPC_HALT;
                end
            end
            LPC_MGMT_SAVE: begin
                nxt_save = !state_saved_in;
                if (state_saved_in) begin
                    nxt_mode  = 1'b1;
                    nxt_state = LPC_MGMT_ACK;
                    nxt_ack   = '{valid: 1'b1, kind: LPC_ACK_MGMT};
                end
            end
            LPC_MGMT_ACK: begin
                nxt_ack = ack_ff;
                if (ack_done_in) begin
                    nxt_ack   = '{valid: 1'b0, kind: LPC_ACK_NONE};
                    nxt_start = 1'b1;
                    nxt_state = LPC_MGMT_RUN;
                end
            end
            LPC_MGMT_RUN: begin
                if (req.halt_req) begin
                    nxt_state = LPC_HALT_ACK;
                    nxt_ack   = '{valid: 1'b1, kind: LPC_ACK_HALT};
                end else if (mgmt_exit_in) begin
                    nxt_mode  = 1'b0;
                    nxt_state = LPC_RUN;
                end
            end
            default: nxt_state = LPC_RUN;
        endcase
        // Management edge latched except while asleep
        // Set after the case so a fresh edge outlives the cycle that consumes the old one
        if (mgmt_edge && state_ff != LPC_SLEEP) begin
            nxt_mgmt_pend = 1'b1;
        end
        nxt_gate  = gates_for(nxt_state);
        // Gated on the next state so the first sleep cycle is already deaf
        nxt_snoop = req.snoop_req && (nxt_state != LPC_SLEEP);
        nxt_exec  = (nxt_state == LPC_RUN) || (nxt_state == LPC_MGMT_RUN);
        // Pending interrupts serviced only once executing again
        nxt_svc   = intr_pending && exec_ff && nxt_exec;
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_ff     <= LPC_RUN;
            gate_ff      <= GATES_ALL_ON;
            mgmt_pend_ff <= 1'b0;
            mgmt_prev_ff <= 1'b0;
            ack_ff       <= '{valid: 1'b0, kind: LPC_ACK_NONE};
            snoop_ff     <= 1'b0;
            svc_ff       <= 1'b0;
            save_ff      <= 1'b0;
            start_ff     <= 1'b0;
            mode_ff      <= 1'b0;
            exec_ff      <= 1'b1;
        end else begin
            state_ff     <= nxt_state;
            gate_ff      <= nxt_gate;
            mgmt_pend_ff <= nxt_mgmt_pend;
            mgmt_prev_ff <= nxt_mgmt_prev;
            ack_ff       <= nxt_ack;
            snoop_ff     <= nxt_snoop;
            svc_ff       <= nxt_svc;
            save_ff      <= nxt_save;
            start_ff     <= nxt_start;
            mode_ff      <= nxt_mode;
            exec_ff      <= nxt_exec;
        end
    end

    assign clk_gate_en_out          = gate_ff;
    assign bus_ack_out              = ack_ff;
    assign snoop_accept_out         = snoop_ff;
    assign intr_service_out         = svc_ff;
    assign save_state_out           = save_ff;
    assign mgmt_handler_start_out   = start_ff;
    assign privileged_mgmt_mode_out = mode_ff;
    assign executing_out            = exec_ff;
    assign state_out                = state_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_sleep_entry: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (state_ff == LPC_HALT && req.halt_req && req.sleep_req) |=> state_ff == LPC_SLEEP)
        else $error("sleep not entered from halt");
    a_sleep_gates: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (state_ff == LPC_SLEEP) |-> clk_gate_en_out == GATES_SLEEP)
        else $error("sleep gates wrong");
    a_sleep_deaf: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (state_ff == LPC_SLEEP) |-> !snoop_accept_out)
        else $error("snoop accepted in sleep");
    a_sleep_only: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (state_ff == LPC_SLEEP && req.sleep_req) |=> state_ff == LPC_SLEEP)
        else $error("sleep left without release");
    a_sleep_exit: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (state_ff == LPC_SLEEP && !req.sleep_req) |=> state_ff == LPC_HALT
        && clk_gate_en_out[GATE_BUS_BIT] && clk_gate_en_out[GATE_ICU_BIT])
        else $error("sleep exit wrong");
    a_halt_ack: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (state_ff == LPC_RUN && req.halt_req) |=> bus_ack_out.valid
        && bus_ack_out.kind == LPC_ACK_HALT)
        else $error("halt ack missing");
    a_halt_gates: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (state_ff == LPC_HALT) |-> clk_gate_en_out == GATES_HALT)
        else $error("halt gates wrong");
    a_halt_exit: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (state_ff == LPC_HALT && !req.halt_req) |=> clk_gate_en_out == GATES_ALL_ON)
        else $error("clocks not restored");
    a_mgmt_ack: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (state_ff == LPC_MGMT_SAVE && state_saved_in) |=> privileged_mgmt_mode_out
        && bus_ack_out.kind == LPC_ACK_MGMT)
        else $error("mgmt ack missing");
    a_sleep_nointr: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (state_ff == LPC_SLEEP && !intr_pending) |=> !intr_pending)
        else $error("interrupt latched in sleep");
    a_sleep_nomgmt: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (state_ff == LPC_SLEEP && !mgmt_pend_ff) |=> !mgmt_pend_ff)
        else $error("mgmt latched in sleep");
    a_ack_hold: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (bus_ack_out.valid && !ack_done_in) |=> $stable(bus_ack_out))
        else $error("acknowledge dropped early");
    a_halt_exec: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (state_ff == LPC_HALT) |-> !executing_out && !intr_service_out)
        else $error("core active in halt");
    a_halt_snoop: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (state_ff == LPC_HALT && req.halt_req && !req.sleep_req && req.snoop_req)
        |=> snoop_accept_out)
        else $error("snoop dropped in halt");
    a_halt_pend: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (state_ff == LPC_HALT && req.intr_req) |=> intr_pending)
        else $error("interrupt not held pending");
    a_pend_svc: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (state_ff == LPC_RUN && intr_pending && !req.halt_req && !mgmt_pend_ff)
        |=> intr_service_out)
        else $error("pending interrupt not serviced");
    a_run_gates: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (state_ff == LPC_RUN) |-> clk_gate_en_out == GATES_ALL_ON && executing_out)
        else $error("run state not fully clocked");
    a_bus_clock: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        clk_gate_en_out[GATE_PLL_BIT]
        && (state_ff == LPC_SLEEP || clk_gate_en_out[GATE_BUS_BIT]))
        else $error("bus clock gated");
    a_mgmt_save: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (state_ff == LPC_RUN && !req.halt_req && mgmt_pend_ff) |=> state_ff == LPC_MGMT_SAVE
        && save_state_out)
        else $error("state save not started");
    a_mgmt_start: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (state_ff == LPC_MGMT_ACK && ack_done_in) |=> state_ff == LPC_MGMT_RUN
        && mgmt_handler_start_out && !bus_ack_out.valid)
        else $error("handler not started");
    a_reset_run: assert property (@(posedge core_clk_in)
        !arst_n_in |=> state_ff == LPC_RUN && clk_gate_en_out == GATES_ALL_ON && executing_out)
        else $error("reset left low-power state");

endmodule // lpc_ctrl
`default_nettype wire

// ==== logic/lpc_pend.sv ====
// Pending interrupt latch; holds a captured interrupt until serviced
`timescale 1ns/1ps
`default_nettype none
module lpc_pend (
    input  wire logic core_clk_in,
    input  wire logic arst_n_in,
    input  wire logic capture_in,
    input  wire logic service_in,
    output logic      pending_out
);
    logic pend_ff;
    logic nxt_pend;

    // Set wins over service in the same cycle
    always_comb begin
        nxt_pend = pend_ff;
        if (service_in) begin
            nxt_pend = 1'b0;
        end
        if (capture_in) begin
            nxt_pend = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pend_ff <= 1'b0;
        end else begin
            pend_ff <= nxt_pend;
        end
    end

    assign pending_out = pend_ff;
endmodule // lpc_pend
`default_nettype wire

// ==== logic/lpc_pkg.sv ====
// Shared types and constants for the low-power state and management control block
package lpc_pkg;

    localparam int SYNC_STAGES = 2;

    // Clock gate vector bit positions
    localparam int GATE_CORE_BIT = 0;
    localparam int GATE_BUS_BIT  = 1;
    localparam int GATE_ICU_BIT  = 2;
    localparam int GATE_PLL_BIT  = 3;
    localparam int GATE_W        = 4;

    localparam logic [GATE_W-1:0] GATES_ALL_ON = 4'hf;
    localparam logic [GATE_W-1:0] GATES_HALT   = 4'he;
    localparam logic [GATE_W-1:0] GATES_SLEEP  = 4'h8;

    typedef enum logic [2:0] {
        LPC_RUN      = 3'b000,
        LPC_HALT_ACK = 3'b001,
        LPC_HALT     = 3'b010,
        LPC_SLEEP    = 3'b011,
        LPC_MGMT_SAVE = 3'b100,
        LPC_MGMT_ACK = 3'b101,
        LPC_MGMT_RUN = 3'b110
    } lpc_state_e;

    typedef enum logic [1:0] {
        LPC_ACK_NONE = 2'h0,
        LPC_ACK_HALT = 2'h1,
        LPC_ACK_MGMT = 2'h2
    } lpc_ack_e;

    // Synchronised request levels, active high
    typedef struct packed {
        logic sleep_req;
        logic halt_req;
        logic mgmt_req;
        logic intr_req;
        logic snoop_req;
    } lpc_req_s;

    // Bus acknowledge transaction request toward the bus unit
    typedef struct packed {
        logic     valid;
        lpc_ack_e kind;
    } lpc_ack_s;

endpackage

// ==== logic/lpc_sync.sv ====
// Two-flop level synchroniser for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module lpc_sync #(
    parameter int         WIDTH    = 1,
    parameter logic [0:0] RST_VAL  = 1'b0
) (
    input  wire logic             core_clk_in,
    input  wire logic             arst_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_sync;

    always_comb begin
        nxt_meta = async_in;
        nxt_sync = meta_ff;
    end

    // First stage feeds only the second
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            meta_ff <= {WIDTH{RST_VAL}};
            sync_ff <= {WIDTH{RST_VAL}};
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign sync_out = sync_ff;
endmodule // lpc_sync
`default_nettype wire

// ==== tb/lpc_chipset.sv ====
// Chipset-side model driving the power-management request pins
`timescale 1ns/1ps
`default_nettype none
module lpc_chipset
    import lpc_pkg::*;
#(
    parameter int SKEW_NS = 7
) (
    input  wire logic       core_clk_in,
    input  wire logic       arst_n_in,
    input  wire logic       want_halt_in,
    input  wire logic       want_sleep_in,
    input  wire logic       want_mgmt_in,
    input  wire logic [3:0] ack_lat_in,
    input  wire lpc_ack_s   bus_ack_in,
    output wire logic       sleep_request_n_out,
    output wire logic       clock_halt_request_n_out,
    output wire logic       mgmt_interrupt_n_out,
    output logic            ack_done_out
);
    int cnt;
    // Skewed off the clock grid: pins are asynchronous to the bus clock
    assign #SKEW_NS clock_halt_request_n_out = ~want_halt_in;
    assign #SKEW_NS mgmt_interrupt_n_out     = ~want_mgmt_in;
    // Sleep only ever asked for on top of a halt request
    assign #SKEW_NS sleep_request_n_out = ~(want_sleep_in & want_halt_in);

    // Bus unit side: finishes an acknowledge after a chosen latency
    always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ack_done_out <= 1'b0;
            cnt <= 0;
        end else begin
            ack_done_out <= 1'b0;
            if (bus_ack_in.valid && !ack_done_out) begin
                if (cnt >= int'(ack_lat_in)) begin
                    ack_done_out <= 1'b1;
                    cnt <= 0;
                end else begin
                    cnt <= cnt + 1;
                end
            end else begin
                cnt <= 0;
            end
        end
    end
endmodule // lpc_chipset
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking testbench for the low-power state controller
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import lpc_pkg::*;
;
    typedef struct {logic halt; logic sleep; lpc_state_e st; logic [3:0] gates;} lpc_row_s;
    logic core_clk_in, arst_n_in, want_halt, want_sleep, want_mgmt, intr, snoop;
    logic state_saved, mgmt_exit, intr_taken, ack_done;
    logic [3:0] ack_lat, gates;
    wire logic slp_n, halt_n, mgmt_n;
    lpc_ack_s bus_ack;
    lpc_state_e state;
    logic snoop_acc, intr_srv, save_st, h_start, pmode, exec_o;
    int err_count, checks_done;
    lpc_row_s rows[6];

    lpc_chipset chip (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
        .want_halt_in(want_halt), .want_sleep_in(want_sleep), .want_mgmt_in(want_mgmt),
        .ack_lat_in(ack_lat), .bus_ack_in(bus_ack), .sleep_request_n_out(slp_n),
        .clock_halt_request_n_out(halt_n), .mgmt_interrupt_n_out(mgmt_n),
        .ack_done_out(ack_done));
    lpc_ctrl dut (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
        .sleep_request_n_in(slp_n), .clock_halt_request_n_in(halt_n),
        .mgmt_interrupt_n_in(mgmt_n), .intr_in(intr), .snoop_in(snoop),
        .ack_done_in(ack_done), .state_saved_in(state_saved), .mgmt_exit_in(mgmt_exit),
        .intr_taken_in(intr_taken), .clk_gate_en_out(gates), .bus_ack_out(bus_ack),
        .snoop_accept_out(snoop_acc), .intr_service_out(intr_srv),
        .save_state_out(save_st), .mgmt_handler_start_out(h_start),
        .privileged_mgmt_mode_out(pmode), .executing_out(exec_o), .state_out(state));

    initial begin
        core_clk_in = 1'b0;
        forever #12.5 core_clk_in = ~core_clk_in;
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge core_clk_in);
        #2;
    endtask

    // Bounded wait for a state; running out ends the run
    task automatic wait_state(input lpc_state_e s);
        int n;
        n = 0;
        while (state !== s && n < 40) begin
            step(1);
            n++;
        end
        chk("state", 8'(state), 8'(s));
        if (state !== s) print_verdict();
    endtask

    initial begin
        {want_halt, want_sleep, want_mgmt, intr, snoop} = 5'h00;
        {state_saved, mgmt_exit, intr_taken} = 3'h0;
        ack_lat = 4'h0;
        err_count = 0;
        checks_done = 0;
        arst_n_in = 1'b0;
        rows = '{'{1'b0, 1'b0, LPC_RUN, GATES_ALL_ON}, '{1'b1, 1'b0, LPC_HALT, GATES_HALT},
                 '{1'b1, 1'b1, LPC_SLEEP, GATES_SLEEP}, '{1'b1, 1'b0, LPC_HALT, GATES_HALT},
                 '{1'b0, 1'b0, LPC_RUN, GATES_ALL_ON}, '{1'b1, 1'b1, LPC_SLEEP, GATES_SLEEP}};
        step(5);
        chk("gates", 8'(gates), 8'(GATES_ALL_ON));
        chk("exec", 8'(exec_o), 8'h01);
        arst_n_in = 1'b1;
        step(2);
        foreach (rows[i]) begin
            want_halt = rows[i].halt;
            want_sleep = rows[i].sleep;
            wait_state(rows[i].st);
            chk("gates", 8'(gates), 8'(rows[i].gates));
        end
        // Sleeping: snoop, interrupt and management request all ignored
        {snoop, intr, want_mgmt} = 3'h7;
        step(8);
        chk("snoop", 8'(snoop_acc), 8'h00);
        chk("state", 8'(state), 8'(LPC_SLEEP));
        {intr, want_mgmt, want_sleep} = 3'h0;
        wait_state(LPC_HALT);
        step(6);
        chk("snoop", 8'(snoop_acc), 8'h01);
        want_halt = 1'b0;
        wait_state(LPC_RUN);
        step(6);
        chk("state", 8'(state), 8'(LPC_RUN));
        chk("intr", 8'(intr_srv), 8'h00);
        // Slow halt-grant; interrupt caught while halted, serviced on release
        ack_lat = 4'h6;
        want_halt = 1'b1;
        wait_state(LPC_HALT_ACK);
        chk("exec", 8'(exec_o), 8'h00);
        chk("ack", 8'(bus_ack), 8'({1'b1, LPC_ACK_HALT}));
        chk("gates", 8'(gates), 8'(GATES_HALT));
        wait_state(LPC_HALT);
        chk("ack", 8'(bus_ack.valid), 8'h00);
        intr = 1'b1;
        step(5);
        intr = 1'b0;
        want_halt = 1'b0;
        wait_state(LPC_RUN);
        chk("exec", 8'(exec_o), 8'h01);
        step(1);
        chk("intr", 8'(intr_srv), 8'h01);
        intr_taken = 1'b1;
        step(1);
        intr_taken = 1'b0;
        step(2);
        chk("intr", 8'(intr_srv), 8'h00);
        // Management entry, save, acknowledge, handler, exit
        want_mgmt = 1'b1;
        wait_state(LPC_MGMT_SAVE);
        chk("save", 8'(save_st), 8'h01);
        want_mgmt = 1'b0;
        state_saved = 1'b1;
        step(1);
        state_saved = 1'b0;
        wait_state(LPC_MGMT_ACK);
        chk("mode", 8'(pmode), 8'h01);
        chk("ack", 8'(bus_ack), 8'({1'b1, LPC_ACK_MGMT}));
        wait_state(LPC_MGMT_RUN);
        chk("start", 8'(h_start), 8'h01);
        // Halt inside management mode comes back to the handler, no second start
        want_halt = 1'b1;
        wait_state(LPC_HALT);
        chk("mode", 8'(pmode), 8'h01);
        want_halt = 1'b0;
        wait_state(LPC_MGMT_RUN);
        chk("start", 8'(h_start), 8'h00);
        mgmt_exit = 1'b1;
        step(1);
        mgmt_exit = 1'b0;
        wait_state(LPC_RUN);
        chk("mode", 8'(pmode), 8'h00);
        chk("start", 8'(h_start), 8'h00);
        // Reset straight out of sleep
        ack_lat = 4'h0;
        {want_halt, want_sleep} = 2'h3;
        wait_state(LPC_SLEEP);
        arst_n_in = 1'b0;
        step(1);
        chk("state", 8'(state), 8'(LPC_RUN));
        chk("gates", 8'(gates), 8'(GATES_ALL_ON));
        {want_halt, want_sleep, snoop} = 3'h0;
        step(2);
        arst_n_in = 1'b1;
        step(1);
        chk("state", 8'(state), 8'(LPC_RUN));
        chk("exec", 8'(exec_o), 8'h01);
        step(1);
        chk("gates", 8'(gates), 8'(GATES_ALL_ON));
        chk("ack", 8'(bus_ack), 8'h00);
        step(2);
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
